// file: aop_port.v
// result output port: parallel bus or serial master/slave port
`timescale 1ns/1ps
`default_nettype none
`include "aop_defs.vh"

// Notes on behaviour
// - parallel bus shows channel B when order input low, channel A when high.
// - serial order is A then B when order high, B then A when low.
// - low power select high picks the reduced power conversion mode.
// - serial select low drives parallel bus; high turns pins into serial port.
// - in serial mode the two lowest data bits float.
// - in parallel mode pins 2 to 7 drive the matching result bits.
// - master read-after-convert slows the internal clock by the divider pins.
// - all other serial modes ignore the divider pins.
// - clock source low makes the device drive the serial clock out.
// - clock source high takes the host clock; data follows that clock.
// - master frame sync is active high when polarity low, else active low.
// - clock invert flips the serial clock sense in master and slave.
// - slave mode passes chain input to data out after 32 clocks.
// - master with read mode high shifts previous result during conversion.
// - master with read mode low shifts only after conversion completes.
// - both results sit in a 32-bit shifter, sent MSB first.
// - slave updates data on rising clock edge, falling edge when inverted.
// - frame sync active during master read, pulsed inactive after first channel.
// - divider codes give minimum clock periods 25, 50, 100, 200 ns.
module aop_port (
	input wire I_CLK, // system clock, 40 MHz
	input wire I_RSTN, // async reset, active low
	input wire I_SERIAL_PARALLEL_SELECT_SEL, // serial_parallel_select pin
	input wire I_CH_ORDER_SEL, // channel_order_select pin
	input wire I_LOW_POWER_SEL, // low_power_select pin
	input wire [15:0] I_D, // data bus pin levels
	output wire [15:0] O_D, // data bus pin drive
	output wire [15:0] O_D_OE, // data bus output enables
	input wire I_RES_VALID, // conversion result offered
	input wire [`AOP_RES_W-1:0] I_RES_A, // channel A result
	input wire [`AOP_RES_W-1:0] I_RES_B, // channel B result
	output wire O_RES_READY, // result accepted
	input wire I_CONV_BUSY, // conversion in progress
	output wire O_LOW_POWER // reduced power mode to engine
);

// ----------------------------------------------------------------
// states and helpers
// ----------------------------------------------------------------
localparam ST_IDLE = 2'b01;
localparam ST_SHIFT = 2'b10;

function [3:0] half_cycles;
	input [1:0] code;
	integer ns;
	integer c;
	begin
		case (code)
			2'h0: ns = `AOP_SCLK_MIN_NS_0;
			2'h1: ns = `AOP_SCLK_MIN_NS_1;
			2'h2: ns = `AOP_SCLK_MIN_NS_2;
			default: ns = `AOP_SCLK_MIN_NS_3;
		endcase
		c = (ns + 2 * `AOP_CLK_NS - 1) / (2 * `AOP_CLK_NS);
		if (c < 1) begin
			c = 1;
		end
		half_cycles = c[3:0];
	end
endfunction

// channel that leaves first: A when the order pin is high, else B
function [`AOP_RES_W-1:0] lead_result;
	input sel;
	input [`AOP_WORD_W-1:0] w;
	begin
		if (sel) begin
			lead_result = w[`AOP_WORD_W-1:`AOP_RES_W];
		end else begin
			lead_result = w[`AOP_RES_W-1:0];
		end
	end
endfunction

// channel that follows the lead one in a serial read
function [`AOP_RES_W-1:0] trail_result;
	input sel;
	input [`AOP_WORD_W-1:0] w;
	begin
		if (sel) begin
			trail_result = w[`AOP_RES_W-1:0];
		end else begin
			trail_result = w[`AOP_WORD_W-1:`AOP_RES_W];
		end
	end
endfunction

// ----------------------------------------------------------------
// pin synchronisers
// ----------------------------------------------------------------
reg [18:0] meta_q;
reg [18:0] pin_q;
reg ext_sclk_prev_q;

always @(posedge I_CLK or negedge I_RSTN) begin
	if (!I_RSTN) begin
		meta_q <= 19'h00000;
		pin_q <= 19'h00000;
		ext_sclk_prev_q <= 1'b0;
	end else begin
		meta_q <= {I_LOW_POWER_SEL, I_CH_ORDER_SEL, I_SERIAL_PARALLEL_SELECT_SEL, I_D};
		pin_q <= meta_q;
		ext_sclk_prev_q <= pin_q[`AOP_PIN_SCLK];
	end
end

wire ser_mode = pin_q[16];
wire ch_order = pin_q[17];
wire low_power = pin_q[18];
wire clk_src_ext = pin_q[`AOP_PIN_CLK_SRC];
wire fsync_pol = pin_q[`AOP_PIN_FSYNC_POL];
wire sclk_inv = pin_q[`AOP_PIN_SCLK_INV];
wire read_mode_or_chain_in = pin_q[`AOP_PIN_READ_MODE_OR_CHAIN_IN];
wire [1:0] div_code = pin_q[`AOP_PIN_DIV_HI:`AOP_PIN_DIV_LO];
wire ext_sclk = pin_q[`AOP_PIN_SCLK];

// ----------------------------------------------------------------
// result buffer
// ----------------------------------------------------------------
wire [`AOP_WORD_W-1:0] in_word;
wire buf_valid;
wire [`AOP_WORD_W-1:0] buf_word;
wire buf_pop;

assign in_word = {I_RES_A, I_RES_B};

aop_buf u_buf (
	.i_clk(I_CLK),
	.i_rstn(I_RSTN),
	.i_in_valid(I_RES_VALID),
	.i_in_data(in_word),
	.o_in_ready(O_RES_READY),
	.o_out_valid(buf_valid),
	.o_out_data(buf_word),
	.i_out_ready(buf_pop)
);

// ----------------------------------------------------------------
// serial engine
// ----------------------------------------------------------------
reg [1:0] st_q;
reg [1:0] st_d;
reg [`AOP_WORD_W-1:0] sh_q;
reg [`AOP_WORD_W-1:0] sh_d;
reg [5:0] bit_q;
reg [5:0] bit_d;
reg [3:0] div_q;
reg [3:0] div_d;
reg sclk_q;
reg sclk_d;
reg [`AOP_WORD_W-1:0] par_q;
reg [`AOP_WORD_W-1:0] par_d;
reg load;
reg fsync_act;

wire master = ser_mode && !clk_src_ext;
wire slave = ser_mode && clk_src_ext;
wire [3:0] half = (master && !read_mode_or_chain_in) ? half_cycles(div_code) : half_cycles(2'h0);
wire start_ok = read_mode_or_chain_in ? 1'b1 : !I_CONV_BUSY;
wire ext_rise = ext_sclk && !ext_sclk_prev_q;
wire ext_fall = !ext_sclk && ext_sclk_prev_q;
wire ext_active = sclk_inv ? ext_fall : ext_rise;
wire [`AOP_WORD_W-1:0] ordered = {lead_result(ch_order, buf_word), trail_result(ch_order, buf_word)};

assign buf_pop = load;

always @* begin
	st_d = st_q;
	sh_d = sh_q;
	bit_d = bit_q;
	div_d = div_q;
	sclk_d = sclk_q;
	par_d = par_q;
	load = 1'b0;
	if (!ser_mode) begin
		st_d = ST_IDLE;
		sclk_d = 1'b0;
		if (buf_valid) begin
			load = 1'b1;
			par_d = buf_word;
		end
	end else begin
		case (st_q)
			ST_IDLE: begin
				sclk_d = 1'b0;
				div_d = 4'h0;
				if (buf_valid && (slave || start_ok)) begin
					load = 1'b1;
					sh_d = ordered;
					bit_d = 6'h00;
					st_d = ST_SHIFT;
				end
			end
			ST_SHIFT: begin
				if (slave) begin
					if (ext_active) begin
						sh_d = {sh_q[`AOP_WORD_W-2:0], read_mode_or_chain_in};
						if (bit_q != `AOP_WORD_BITS) begin
							bit_d = bit_q + 6'h01;
						end
					end else if (buf_valid && bit_q == `AOP_WORD_BITS) begin
						load = 1'b1;
						sh_d = ordered;
						bit_d = 6'h00;
					end
				end else begin
					if (div_q + 4'h1 >= half) begin
						div_d = 4'h0;
						sclk_d = ~sclk_q;
						if (sclk_q) begin
							sh_d = {sh_q[`AOP_WORD_W-2:0], 1'b0};
							bit_d = bit_q + 6'h01;
							if (bit_q + 6'h01 == `AOP_WORD_BITS) begin
								st_d = ST_IDLE;
							end
						end
					end else begin
						div_d = div_q + 4'h1;
					end
				end
			end
			default: begin
				st_d = ST_IDLE;
			end
		endcase
	end
end

always @(posedge I_CLK or negedge I_RSTN) begin
	if (!I_RSTN) begin
		st_q <= ST_IDLE;
		sh_q <= `AOP_WORD_RESET;
		bit_q <= 6'h00;
		div_q <= 4'h0;
		sclk_q <= 1'b0;
		par_q <= `AOP_WORD_RESET;
	end else begin
		st_q <= st_d;
		sh_q <= sh_d;
		bit_q <= bit_d;
		div_q <= div_d;
		sclk_q <= sclk_d;
		par_q <= par_d;
	end
end

// ----------------------------------------------------------------
// frame sync: active over a master read, one inactive gap at bit 16
// ----------------------------------------------------------------
always @* begin
	fsync_act = (st_q == ST_SHIFT) && master;
	if (bit_q == 6'h10 && !sclk_q) begin
		fsync_act = 1'b0;
	end
end

// ----------------------------------------------------------------
// pin drive
// ----------------------------------------------------------------
reg [15:0] d_q;
reg [15:0] oe_q;
reg low_power_q;

always @(posedge I_CLK or negedge I_RSTN) begin
	if (!I_RSTN) begin
		d_q <= 16'h0000;
		oe_q <= `AOP_OE_RESET;
		low_power_q <= 1'b0;
	end else begin
		low_power_q <= low_power;
		if (!ser_mode) begin
			d_q <= lead_result(ch_order, par_q);
			oe_q <= 16'hFFFF;
		end else begin
			d_q <= 16'h0000;
			d_q[`AOP_PIN_SERIAL_DATA_OUT] <= sh_d[`AOP_WORD_W-1];
			d_q[`AOP_PIN_SCLK] <= sclk_d ^ sclk_inv;
			d_q[`AOP_PIN_FSYNC] <= fsync_act ^ fsync_pol;
			oe_q <= 16'h0000;
			oe_q[`AOP_PIN_SERIAL_DATA_OUT] <= 1'b1;
			oe_q[`AOP_PIN_SCLK] <= master;
			oe_q[`AOP_PIN_FSYNC] <= 1'b1;
			oe_q[`AOP_PIN_RDERR] <= 1'b1;
		end
	end
end

assign O_D = d_q;
assign O_D_OE = oe_q;
assign O_LOW_POWER = low_power_q;

endmodule // aop_port
`default_nettype wire

// file: aop_defs.vh
// constants for the converter result output port
`ifndef AOP_DEFS_VH
`define AOP_DEFS_VH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define AOP_RES_W 16
`define AOP_WORD_W 32
`define AOP_BUF_DEPTH 2
`define AOP_WORD_BITS 6'h20

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define AOP_CLK_NS 25
`define AOP_SCLK_MIN_NS_0 25
`define AOP_SCLK_MIN_NS_1 50
`define AOP_SCLK_MIN_NS_2 100
`define AOP_SCLK_MIN_NS_3 200

// ----------------------------------------------------------------
// data bus pin positions in serial mode
// ----------------------------------------------------------------
`define AOP_PIN_DIV_LO 2
`define AOP_PIN_DIV_HI 3
`define AOP_PIN_CLK_SRC 4
`define AOP_PIN_FSYNC_POL 5
`define AOP_PIN_SCLK_INV 6
`define AOP_PIN_READ_MODE_OR_CHAIN_IN 7
`define AOP_PIN_SERIAL_DATA_OUT 8
`define AOP_PIN_SCLK 9
`define AOP_PIN_FSYNC 10
`define AOP_PIN_RDERR 11

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define AOP_OE_RESET 16'h0000
`define AOP_WORD_RESET 32'h00000000

`endif

// file: aop_buf.v
// two-entry result buffer with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
`include "aop_defs.vh"

module aop_buf (
	input wire i_clk, // system clock
	input wire i_rstn, // async reset, active low
	input wire i_in_valid, // word offered
	input wire [`AOP_WORD_W-1:0] i_in_data, // offered word
	output wire o_in_ready, // space free
	output wire o_out_valid, // word held
	output wire [`AOP_WORD_W-1:0] o_out_data, // oldest word
	input wire i_out_ready // drain accepts
);

reg [`AOP_WORD_W-1:0] mem [0:`AOP_BUF_DEPTH-1];
reg wr_q;
reg rd_q;
reg [1:0] cnt_q;
wire push;
wire pop;

assign o_in_ready = (cnt_q != 2'h2);
assign o_out_valid = (cnt_q != 2'h0);
assign o_out_data = mem[rd_q];
assign push = i_in_valid && o_in_ready;
assign pop = o_out_valid && i_out_ready;

always @(posedge i_clk) begin
	if (push) begin
		mem[wr_q] <= i_in_data;
	end
end

always @(posedge i_clk or negedge i_rstn) begin
	if (!i_rstn) begin
		wr_q <= 1'b0;
		rd_q <= 1'b0;
		cnt_q <= 2'h0;
	end else begin
		if (push) begin
			wr_q <= ~wr_q;
		end
		if (pop) begin
			rd_q <= ~rd_q;
		end
		if (push && !pop) begin
			cnt_q <= cnt_q + 2'h1;
		end else if (pop && !push) begin
			cnt_q <= cnt_q - 2'h1;
		end
	end
end

endmodule // aop_buf
`default_nettype wire

// file: aop_port_asserts.sv
// pin-level checks for the result output port
`timescale 1ns/1ps
`default_nettype none
module aop_port_asserts (
	input wire logic I_CLK, // clock
	input wire logic I_RSTN, // reset
	input wire logic I_SERIAL_PARALLEL_SELECT_SEL, // port mode
	input wire logic I_CH_ORDER_SEL, // order
	input wire logic I_LOW_POWER_SEL, // power mode
	input wire logic [15:0] I_D, // bus levels
	input wire logic [15:0] O_D, // bus drive
	input wire logic [15:0] O_D_OE, // enables
	input wire logic I_RES_VALID, // offer
	input wire logic [15:0] I_RES_A, // channel a
	input wire logic [15:0] I_RES_B, // channel b
	input wire logic O_RES_READY, // space
	input wire logic I_CONV_BUSY, // conversion running
	input wire logic O_LOW_POWER // power out
);
	default clocking @(posedge I_CLK); endclocking
	default disable iff (!I_RSTN);
	sequence par_s; (!I_SERIAL_PARALLEL_SELECT_SEL && $stable(I_CH_ORDER_SEL)) [*5]; endsequence
	sequence mst_s; (I_SERIAL_PARALLEL_SELECT_SEL && !I_D[4]) [*5]; endsequence
	sequence slv_s; (I_SERIAL_PARALLEL_SELECT_SEL && I_D[4]) [*5]; endsequence
	// no word offered and no conversion, so no read can be starting
	sequence quiet_s; (I_SERIAL_PARALLEL_SELECT_SEL && !I_D[4] && !I_RES_VALID && !I_CONV_BUSY &&
		$stable(I_D[5]) && $stable(O_D[9])) [*8];
	endsequence
	property par_data_p;
		(par_s ##0 (I_RES_VALID && O_RES_READY))
			|-> ##3 O_D == (I_CH_ORDER_SEL ? $past(I_RES_A, 3) : $past(I_RES_B, 3));
	endproperty
	par_oe_a: assert property (par_s |-> O_D_OE == 16'hFFFF)
		else $error("parallel enables wrong");
	ser_float_a: assert property (I_SERIAL_PARALLEL_SELECT_SEL [*5] |-> O_D_OE[1:0] == 2'h0)
		else $error("low bits not floating");
	power_follow_a: assert property ($stable(I_LOW_POWER_SEL) [*5] |-> O_LOW_POWER == I_LOW_POWER_SEL)
		else $error("power mode wrong");
	par_ready_a: assert property (par_s |-> O_RES_READY)
		else $error("parallel stalled");
	par_data_a: assert property (par_data_p)
		else $error("parallel word wrong");
	master_clk_a: assert property (mst_s |-> O_D_OE[9] && O_D_OE[8])
		else $error("master clock not driven");
	slave_clk_a: assert property (slv_s |-> !O_D_OE[9])
		else $error("slave clock driven");
	frame_idle_a: assert property (quiet_s |-> O_D[10] == I_D[5])
		else $error("idle frame level wrong");
endmodule // aop_port_asserts
bind aop_port aop_port_asserts u_chk (.I_CLK, .I_RSTN, .I_SERIAL_PARALLEL_SELECT_SEL, .I_CH_ORDER_SEL,
	.I_LOW_POWER_SEL, .I_D, .O_D, .O_D_OE, .I_RES_VALID, .I_RES_A, .I_RES_B, .O_RES_READY,
	.I_CONV_BUSY, .O_LOW_POWER);
`default_nettype wire

// file: aop_host.sv
// host model capturing the serial result stream
`timescale 1ns/1ps
`default_nettype none
module aop_host (
	input wire logic clk, // clock
	input wire logic clr, // restart capture
	input wire logic inv, // clock inverted
	input wire logic ext, // host clocks the port
	input wire logic sclk, // serial clock pin
	input wire logic sdo, // serial data pin
	output logic [31:0] word, // last 32 bits
	output logic [7:0] bits, // bits taken
	output logic [3:0] half // last half period
);
	logic prev = 1'b0;
	logic [3:0] cnt = 4'h0;
	always @(posedge clk) begin
		prev <= sclk;
		cnt <= (sclk != prev) ? 4'h1 : cnt + 4'h1;
		if (sclk != prev)
			half <= cnt;
		if (clr)
			bits <= 8'h00;
		else if (sclk != prev && (sclk ^ inv ^ ext)) begin
			word <= {word[30:0], sdo};
			bits <= bits + 8'h01;
		end
	end
endmodule // aop_host
`default_nettype wire

// file: aop_port_bench.sv
// self-checking bench for the result output port
`timescale 1ns/1ps
`default_nettype none
module aop_port_bench;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic ser = 1'b0;
	logic ord = 1'b0;
	logic lp = 1'b0;
	logic valid = 1'b0;
	logic busy = 1'b0;
	logic clr = 1'b0;
	logic [15:0] drv = 16'h0000;
	logic [15:0] ra = 16'h0000;
	logic [15:0] rb = 16'h0000;
	wire [15:0] d_out;
	wire [15:0] d_oe;
	wire [15:0] d_in;
	wire ready;
	wire lp_out;
	wire [31:0] word;
	wire [7:0] bits;
	wire [3:0] half;
	int n_mismatch = 0;
	int cmp_count = 0;
	assign d_in = (d_oe & d_out) | (~d_oe & drv);
	always #12.5 clk = ~clk;
	aop_port u_dut (.I_CLK(clk), .I_RSTN(rstn), .I_SERIAL_PARALLEL_SELECT_SEL(ser), .I_CH_ORDER_SEL(ord),
		.I_LOW_POWER_SEL(lp), .I_D(d_in), .O_D(d_out), .O_D_OE(d_oe), .I_RES_VALID(valid),
		.I_RES_A(ra), .I_RES_B(rb), .O_RES_READY(ready), .I_CONV_BUSY(busy),
		.O_LOW_POWER(lp_out));
	aop_host u_host (.clk(clk), .clr(clr), .inv(drv[6]), .ext(drv[4]), .sclk(d_in[9]),
		.sdo(d_out[8]), .word(word), .bits(bits), .half(half));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic offer(input logic [15:0] a, input logic [15:0] b);
		@(posedge clk);
		ra <= a;
		rb <= b;
		valid <= 1'b1;
		@(negedge clk);
		while (ready !== 1'b1) @(negedge clk);
		@(posedge clk);
		valid <= 1'b0;
	endtask
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic t_par;
		for (int o = 0; o < 2; o++) begin
			@(posedge clk);
			ser <= 1'b0;
			ord <= o[0];
			lp <= o[0];
			idle(6);
			offer(16'hA5C3, 16'h3C5A);
			idle(6);
			@(negedge clk);
			chk({16'h0, d_out}, o ? 32'h0000A5C3 : 32'h00003C5A);
			chk({16'h0, d_oe}, 32'h0000FFFF);
			chk({31'h0, lp_out}, {31'h0, o[0]});
		end
	endtask
	// cfg holds read mode, invert, polarity, divider
	task automatic t_mst(input logic o, input logic [4:0] cfg, input logic [3:0] eh);
		@(posedge clk);
		ser <= 1'b1;
		ord <= o;
		drv <= {8'h00, cfg[4:2], 1'b0, cfg[1:0], 2'h0};
		idle(6);
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
		offer(16'h8E71, 16'h4D2B);
		for (int i = 0; i < 2000 && bits != 8'h20; i++) @(posedge clk);
		idle(4);
		chk(word, o ? 32'h8E714D2B : 32'h4D2B8E71);
		chk({28'h0, half}, {28'h0, eh});
	endtask
	task automatic t_hold;
		@(posedge clk);
		busy <= 1'b1;
		clr <= 1'b1;
		offer(16'h1234, 16'hFEDC);
		clr <= 1'b0;
		offer(16'h0F0F, 16'hF0F0);
		idle(30);
		@(negedge clk);
		chk({31'h0, ready}, 32'h0);
		chk({24'h0, bits}, 32'h0);
		@(posedge clk);
		busy <= 1'b0;
		for (int i = 0; i < 2000 && bits != 8'h40; i++) @(posedge clk);
		chk(word, 32'hF0F00F0F);
	endtask
	// slave read: clock idles high, chain input high, 64 host periods
	task automatic t_slv;
		@(posedge clk);
		ser <= 1'b1;
		ord <= 1'b1;
		drv <= 16'h0290;
		idle(6);
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
		offer(16'h6B19, 16'hC2E4);
		idle(4);
		for (int i = 0; i < 64; i++) begin
			drv[9] <= 1'b0;
			idle(8);
			if (i == 31) begin
				chk(word, 32'h6B19C2E4);
			end
			drv[9] <= 1'b1;
			idle(8);
		end
		chk(word, 32'hFFFFFFFF);
		chk({24'h0, bits}, 32'h00000040);
	endtask
	initial begin
		idle(2);
		rstn <= 1'b1;
		t_par;
		t_mst(1'b1, 5'b10000, 4'h1);
		t_mst(1'b0, 5'b10111, 4'h1);
		t_mst(1'b1, 5'b01011, 4'h4);
		t_mst(1'b0, 5'b00110, 4'h2);
		t_hold;
		t_slv;
		tally_and_finish;
	end
	initial begin
		#200000;
		n_mismatch++;
		tally_and_finish;
	end
endmodule // aop_port_bench
`default_nettype wire
